/* src/rrc_pkg.sv */
package rrc_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the serial control bus
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
  localparam logic [7:0] ADDR_GEN_CTRL_WR = 8'h31;
  localparam logic [7:0] ADDR_TX_MIX_WR = 8'h33;
  localparam logic [7:0] ADDR_LO_WR = 8'h3f;
  localparam logic [7:0] ADDR_GEN_CTRL_RD = 8'hc1;
  localparam logic [7:0] ADDR_TX_MIX_RD = 8'hc3;
  localparam logic [7:0] ADDR_STATUS_RD = 8'hc4;
  localparam logic [7:0] ADDR_LO_RD = 8'hcf;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_GEN_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_MIX = 8'h00;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam int unsigned GEN_CTRL_RF_SYNTH_BIT = 0;
  localparam int unsigned GEN_CTRL_IF_SYNTH_BIT = 1;
  localparam int unsigned GEN_CTRL_REFAMP_BIT = 2;
  localparam int unsigned TX_MIX_IMAGE_REJ_BIT = 0;
  localparam int unsigned TX_MIX_HIGH_SIDE_BIT = 1;
  localparam int unsigned LO_DIV_LSB = 0;
  localparam int unsigned STAT_CLK_OK_BIT = 7;
  localparam int unsigned STAT_PWR_DOWN_BIT = 6;

  // ---------------------------------------------------------------
  // Reference clock qualification counts (clock_in cycles / edges)
  // ---------------------------------------------------------------
  localparam logic [4:0] CLK_STABLE_EDGES = 5'h10;
  localparam logic [6:0] CLK_LOSS_CYCLES = 7'h40;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LO_UNDIVIDED = 2'b00,
    LO_DIVIDE_TWO = 2'b01,
    LO_DIVIDE_FOUR = 2'b10
  } rrc_lo_div_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_WDATA = 2'b10,
    BUS_RDATA = 2'b11
  } rrc_bus_state_t;

  typedef struct packed {
    logic csn;
    logic sclk;
    logic cdata;
  } rrc_cbus_t;

  typedef struct packed {
    logic rf_synth_en;
    logic if_synth_en;
    logic tx_image_reject;
    logic tx_high_side;
    logic [1:0] lo_div;
  } rrc_ctrl_t;

endpackage : rrc_pkg

/* src/rrc_clk_gate.sv */
`timescale 1ns/1ps
module rrc_clk_gate
  import rrc_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic soft_rst_in, // Synchronous general reset
  input wire logic amp_en_in, // Reference amplifier on
  input wire logic mclk_in, // Amplified reference clock pin
  output logic clk_ok_out, // Reference clock stable
  output logic dig_clk_out // Gated digital clock
);

  logic [1:0] mclk_sync_q;
  logic mclk_prev_q;
  logic [4:0] edge_cnt_q;
  logic [6:0] idle_cnt_q;
  logic clk_ok_q;
  logic gate_q;
  logic dig_clk_q;
  logic mclk_s;
  logic mclk_rise;

  // ---------------------------------------------------------------
  // Synchroniser and edge detect
  // ---------------------------------------------------------------
  assign mclk_s = mclk_sync_q[1];
  assign mclk_rise = mclk_s & ~mclk_prev_q;

  // Two stages before anything looks at the pin
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mclk_sync_q <= 2'h0;
      mclk_prev_q <= 1'b0;
    end else begin
      mclk_sync_q <= {mclk_sync_q[0], mclk_in};
      mclk_prev_q <= mclk_s;
    end
  end

  // ---------------------------------------------------------------
  // Stability detection
  // ---------------------------------------------------------------
  // Silence watchdog: a stalled amplifier output counts as lost
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idle_cnt_q <= 7'h00;
    end else if (mclk_rise || !amp_en_in) begin
      idle_cnt_q <= 7'h00;
    end else if (idle_cnt_q != CLK_LOSS_CYCLES - 7'h01) begin
      idle_cnt_q <= idle_cnt_q + 7'h01;
    end
  end

  // Clean edges in a row before the clock is trusted
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      edge_cnt_q <= 5'h00;
      clk_ok_q <= 1'b0;
    end else if (soft_rst_in || !amp_en_in || idle_cnt_q == CLK_LOSS_CYCLES - 7'h01) begin
      edge_cnt_q <= 5'h00;
      clk_ok_q <= 1'b0;
    end else if (mclk_rise) begin
      if (edge_cnt_q == CLK_STABLE_EDGES - 5'h01) begin
        clk_ok_q <= 1'b1;
      end else begin
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free gate
  // ---------------------------------------------------------------
  // Enable moves only while the source is low, so the first high is whole
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_q <= 1'b0;
      dig_clk_q <= 1'b0;
    end else begin
      if (!mclk_s) begin
        gate_q <= clk_ok_q;
      end
      dig_clk_q <= mclk_s & gate_q;
    end
  end

  assign clk_ok_out = clk_ok_q;
  assign dig_clk_out = dig_clk_q;

  AST_GATE_ONLY_LOW: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $changed(gate_q) |-> !$past(mclk_s))
    else $error("clock gate changed while source high");

  AST_HOLD_OFF: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (!clk_ok_q && !gate_q) |=> !dig_clk_q)
    else $error("digital clock ran before stable");

  AST_FULL_CYCLE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $rose(dig_clk_q) |-> $past(mclk_rise) && $past(gate_q, 2))
    else $error("truncated first clock pulse");

  AST_STABLE_COUNT: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    $rose(clk_ok_q) |-> $past(edge_cnt_q) == CLK_STABLE_EDGES - 5'h01 && $past(mclk_rise))
    else $error("clock declared stable early");

endmodule : rrc_clk_gate

/* src/rrc_top.sv */
`timescale 1ns/1ps
// Operation
// - Power-up through the digital supply reset leaves the device exactly as a general reset command does.
// - Pulling the external reset pin low gives the same state as general reset and power-up.
// - Both supply rails are watched and a power-down flag rises whenever either is lost.
// - The reference amplifier switches on whenever either synthesiser is enabled, whatever its own bit says.
// - The digital clock is held off until the reference clock is seen to be stable.
// - The first released digital clock pulse is a whole cycle with full high and low phases.
// - Reference clock status reads back as bit 7 of the status word at C4 hex.
// - The transmit mixer has a selectable image-reject mode and a lower-current normal mode.
// - Image reject with the undivided LO is not supported and is not applied by the device.
// - High-side or low-side mixer operation is chosen by a register write.
// - Synthesiser and reference amplifier enables live in the general control register written at 31 hex and read at C1 hex.
// - Mixer configuration is written at 33 hex, read at C3 hex, with Lo_path_control_write written at 3F hex.
module rrc_top
  import rrc_pkg::*;
(
  input wire logic clock_in, // 20 MHz system clock
  input wire logic arst_n_in, // Power-on reset, active low
  input wire rrc_cbus_t cbus_in, // Serial control bus pins
  input wire logic external_reset_low_in, // Reset pin, active low
  input wire logic digital_supply_ok_in, // Digital rail present
  input wire logic analog_supply_ok_in, // Analogue rail present
  input wire logic mclk_in, // Amplified reference clock
  output logic rdata_out, // Serial read data
  output logic rdata_oe_out, // Read data drive enable
  output logic power_down_out, // Supply lost
  output rrc_ctrl_t ctrl_out, // Mixer and synth controls
  output logic refamp_on_out, // Reference amplifier enable
  output logic clk_ok_out, // Reference clock stable
  output logic dig_clk_out // Gated digital clock
);

  logic [1:0][2:0] cbus_sync_q;
  logic [1:0][2:0] misc_sync_q;
  rrc_cbus_t bus_s;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic ext_rst_s;
  logic soft_rst;
  rrc_bus_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_stb_q;
  logic gen_rst_q;
  logic [7:0] rsh_q;
  logic rdata_q;
  logic oe_q;
  logic [7:0] gen_ctrl_q;
  logic [7:0] tx_mix_q;
  logic [7:0] lo_q;
  logic [7:0] rd_word;
  logic [7:0] shift_next;
  logic power_down_q;
  logic refamp_on_q;
  rrc_ctrl_t ctrl_q;
  logic clk_ok;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  assign bus_s = cbus_sync_q[1];
  assign ext_rst_s = misc_sync_q[1][2];
  assign sclk_rise = bus_s.sclk & ~sclk_prev_q;
  assign sclk_fall = ~bus_s.sclk & sclk_prev_q;

  // Bus idles with chip select high; rails read as present until sampled
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cbus_sync_q <= {2{3'b100}};
      misc_sync_q <= {2{3'b111}};
      sclk_prev_q <= 1'b0;
    end else begin
      cbus_sync_q <= {cbus_sync_q[0], cbus_in};
      misc_sync_q <= {misc_sync_q[0], {external_reset_low_in, digital_supply_ok_in, analog_supply_ok_in}};
      sclk_prev_q <= bus_s.sclk;
    end
  end

  // Pin reset and the general reset command share one path
  assign soft_rst = ~ext_rst_s | gen_rst_q;

  // ---------------------------------------------------------------
  // Supply monitor
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_down_q <= 1'b0;
    end else begin
      power_down_q <= ~(misc_sync_q[1][1] & misc_sync_q[1][0]);
    end
  end

  // ---------------------------------------------------------------
  // Serial control bus slave
  // ---------------------------------------------------------------
  assign shift_next = {shift_q[6:0], bus_s.cdata};

  // Read-back selection; unmapped read addresses return zero
  always_comb begin
    rd_word = 8'h00;
    unique case (addr_q)
      ADDR_GEN_CTRL_RD: rd_word = gen_ctrl_q;
      ADDR_TX_MIX_RD: rd_word = tx_mix_q;
      ADDR_LO_RD: rd_word = lo_q;
      ADDR_STATUS_RD: begin
        rd_word[STAT_CLK_OK_BIT] = clk_ok;
        rd_word[STAT_PWR_DOWN_BIT] = power_down_q;
      end
      default: rd_word = 8'h00;
    endcase
  end

  // Address byte first, then one data byte, MSB first, sampled on SCLK rise.
  // SCLK phases must each span several clock_in cycles for the sampling to see them.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= BUS_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_stb_q <= 1'b0;
      gen_rst_q <= 1'b0;
      rsh_q <= 8'h00;
      rdata_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      gen_rst_q <= 1'b0;
      if (bus_s.csn || !ext_rst_s) begin
        // Address alone followed by deselect is the general reset command
        if (bus_s.csn && state_q == BUS_WDATA && bit_cnt_q == 3'h0 && addr_q == ADDR_GEN_RESET) begin
          gen_rst_q <= 1'b1;
        end
        state_q <= BUS_IDLE;
        bit_cnt_q <= 3'h0;
        oe_q <= 1'b0;
        rdata_q <= 1'b0;
      end else begin
        unique case (state_q)
          BUS_IDLE: begin
            state_q <= BUS_ADDR;
            bit_cnt_q <= 3'h0;
          end
          BUS_ADDR: begin
            if (sclk_rise) begin
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7) begin
                addr_q <= shift_next;
                state_q <= shift_next[7] ? BUS_RDATA : BUS_WDATA;
              end
            end
          end
          BUS_WDATA: begin
            if (sclk_rise) begin
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7) begin
                wdata_q <= shift_next;
                wr_stb_q <= 1'b1;
                state_q <= BUS_ADDR;
              end
            end
          end
          BUS_RDATA: begin
            // Bits change on SCLK fall so the host samples them on the rise
            if (sclk_fall) begin
              oe_q <= 1'b1;
              rdata_q <= rsh_q[7];
              rsh_q <= {rsh_q[6:0], 1'b0};
            end
          end
        endcase
        if (state_q == BUS_ADDR && sclk_rise && bit_cnt_q == 3'h7) begin
          rsh_q <= 8'h00;
        end
        if (state_q == BUS_RDATA && !oe_q && !sclk_fall) begin
          rsh_q <= rd_word;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Same values from power-up, the pin and the command
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gen_ctrl_q <= RST_GEN_CTRL;
      tx_mix_q <= RST_TX_MIX;
      lo_q <= RST_LO;
    end else if (soft_rst) begin
      gen_ctrl_q <= RST_GEN_CTRL;
      tx_mix_q <= RST_TX_MIX;
      lo_q <= RST_LO;
    end else if (wr_stb_q) begin
      if (addr_q == ADDR_GEN_CTRL_WR) begin
        gen_ctrl_q <= wdata_q;
      end
      if (addr_q == ADDR_TX_MIX_WR) begin
        tx_mix_q <= wdata_q;
      end
      if (addr_q == ADDR_LO_WR) begin
        lo_q <= wdata_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Derived controls
  // ---------------------------------------------------------------
  // Image reject is withheld on the undivided LO rather than trusting software
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= '0;
      refamp_on_q <= 1'b0;
    end else begin
      ctrl_q.rf_synth_en <= gen_ctrl_q[GEN_CTRL_RF_SYNTH_BIT];
      ctrl_q.if_synth_en <= gen_ctrl_q[GEN_CTRL_IF_SYNTH_BIT];
      ctrl_q.tx_image_reject <= tx_mix_q[TX_MIX_IMAGE_REJ_BIT] &&
        (lo_q[LO_DIV_LSB +: 2] != LO_UNDIVIDED);
      ctrl_q.tx_high_side <= tx_mix_q[TX_MIX_HIGH_SIDE_BIT];
      ctrl_q.lo_div <= lo_q[LO_DIV_LSB +: 2];
      refamp_on_q <= gen_ctrl_q[GEN_CTRL_REFAMP_BIT] | gen_ctrl_q[GEN_CTRL_RF_SYNTH_BIT] |
        gen_ctrl_q[GEN_CTRL_IF_SYNTH_BIT];
    end
  end

  rrc_clk_gate rrc_clk_gate_inst (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .soft_rst_in(soft_rst),
    .amp_en_in(refamp_on_q),
    .mclk_in(mclk_in),
    .clk_ok_out(clk_ok),
    .dig_clk_out(dig_clk_out)
  );

  assign rdata_out = rdata_q;
  assign rdata_oe_out = oe_q;
  assign power_down_out = power_down_q;
  assign ctrl_out = ctrl_q;
  assign refamp_on_out = refamp_on_q;
  assign clk_ok_out = clk_ok;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_addr_done;
    state_q == BUS_ADDR && sclk_rise && bit_cnt_q == 3'h7 && !bus_s.csn && ext_rst_s;
  endsequence

  sequence s_rd_loaded;
    state_q == BUS_RDATA && !oe_q && !sclk_fall && !bus_s.csn && ext_rst_s;
  endsequence

  AST_PWR_DOWN: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    ##3 power_down_out == !($past(digital_supply_ok_in, 3) && $past(analog_supply_ok_in, 3)))
    else $error("power-down flag does not follow rails");

  AST_REFAMP_AUTO: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (gen_ctrl_q[GEN_CTRL_RF_SYNTH_BIT] || gen_ctrl_q[GEN_CTRL_IF_SYNTH_BIT]) |=> refamp_on_out)
    else $error("reference amplifier off with synth enabled");

  AST_IR_NEEDS_DIV: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    ctrl_out.tx_image_reject |-> $past(lo_q[LO_DIV_LSB +: 2]) != LO_UNDIVIDED &&
    $past(tx_mix_q[TX_MIX_IMAGE_REJ_BIT]))
    else $error("image reject on undivided LO");

  AST_SOFT_RESET: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    soft_rst |=> gen_ctrl_q == RST_GEN_CTRL && tx_mix_q == RST_TX_MIX && lo_q == RST_LO)
    else $error("reset did not restore registers");

  AST_TX_MIX_WRITE: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (wr_stb_q && addr_q == ADDR_TX_MIX_WR && !soft_rst) |=> tx_mix_q == $past(wdata_q) ##1
    ctrl_out.tx_high_side == tx_mix_q[TX_MIX_HIGH_SIDE_BIT])
    else $error("mixer config write lost");

  AST_READBACK_TX_MIX: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (s_addr_done ##1 s_rd_loaded) |=> (addr_q != ADDR_TX_MIX_RD) || rsh_q == $past(tx_mix_q))
    else $error("read-back differs from written value");

  AST_STATUS_BIT7: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (s_addr_done ##1 s_rd_loaded) |=> (addr_q != ADDR_STATUS_RD) || rsh_q[7] == $past(clk_ok))
    else $error("status bit 7 not clock status");

endmodule : rrc_top

/* dv/rrc_host_model.sv */
`timescale 1ns/1ps
module rrc_host_model
  import rrc_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic rdata_in, // Serial read data from the device
  input wire logic rdata_oe_in, // Device drives read data
  output rrc_cbus_t cbus_out // Serial bus pins towards the device
);
  // Cycles per sclk phase; the bench raises it to act as a slow host
  int half = 6;

  // Bus idles deselected with sclk low
  initial cbus_out = 3'b100;

  // Changes land just after an edge, never on it
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_cyc

  // Data settles a full phase before the rise that takes it
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      cbus_out.cdata = v[i];
      wait_cyc(half);
      cbus_out.sclk = 1'b1;
      wait_cyc(half);
      cbus_out.sclk = 1'b0;
    end
  endtask : send_byte

  task automatic frame_begin;
    cbus_out.csn = 1'b0;
    wait_cyc(half);
  endtask : frame_begin

  // Released data line shows no stale value
  task automatic frame_end;
    wait_cyc(half);
    cbus_out.csn = 1'b1;
    cbus_out.cdata = ~cbus_out.cdata;
    wait_cyc(2 * half);
  endtask : frame_end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    frame_begin();
    send_byte(a);
    send_byte(d);
    frame_end();
  endtask : write_reg

  // Read data is sampled at the end of each low phase, before the rise
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic oe);
    frame_begin();
    send_byte(a);
    oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      cbus_out.cdata = ~cbus_out.cdata;
      wait_cyc(half);
      d[i] = rdata_in;
      oe = oe & rdata_oe_in;
      cbus_out.sclk = 1'b1;
      wait_cyc(half);
      cbus_out.sclk = 1'b0;
    end
    frame_end();
  endtask : read_reg

  // Address byte alone, then deselect
  task automatic gen_reset;
    frame_begin();
    send_byte(ADDR_GEN_RESET);
    frame_end();
  endtask : gen_reset
endmodule : rrc_host_model

/* dv/rrc_top_tb.sv */
`timescale 1ns/1ps
module rrc_top_tb;
  import rrc_pkg::*;
  localparam int MCLK_HALF = 4; // clock_in cycles per reference phase
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ext_reset_low = 1'b1;
  logic dig_ok = 1'b1;
  logic ana_ok = 1'b1;
  logic mclk = 1'b0;
  logic mclk_run = 1'b0;
  rrc_cbus_t cbus;
  rrc_ctrl_t ctrl;
  logic rdata, rdata_oe, power_down, refamp_on, clk_ok, dig_clk;
  int num_errors = 0;
  int checks = 0;
  int mcnt = 0;
  int hi_len = 0;
  int dig_hi = 0;
  int n;
  logic [7:0] gv [4] = '{8'h01, 8'h02, 8'h04, 8'h00};

  always #25 clock_in = ~clock_in;

  rrc_top rrc_top_inst (.clock_in(clock_in), .arst_n_in(arst_n_in), .cbus_in(cbus),
    .external_reset_low_in(ext_reset_low), .digital_supply_ok_in(dig_ok), .analog_supply_ok_in(ana_ok),
    .mclk_in(mclk), .rdata_out(rdata), .rdata_oe_out(rdata_oe), .power_down_out(power_down),
    .ctrl_out(ctrl), .refamp_on_out(refamp_on), .clk_ok_out(clk_ok), .dig_clk_out(dig_clk));

  rrc_host_model rrc_host_model_inst (.clock_in(clock_in), .rdata_in(rdata), .rdata_oe_in(rdata_oe),
    .cbus_out(cbus));

  // Reference source; always stops low so the gate can close cleanly
  always @(posedge clock_in) begin
    #1;
    if (mclk_run || mclk) begin
      mcnt = (mcnt == MCLK_HALF - 1) ? 0 : mcnt + 1;
      if (mcnt == 0) mclk = ~mclk;
    end
  end

  // Every gated pulse must be a whole reference phase
  always @(posedge clock_in) begin
    if (dig_clk === 1'b1) begin
      hi_len++;
      dig_hi++;
    end else begin
      if (hi_len != 0) check("dig clk high width", hi_len, MCLK_HALF);
      hi_len = 0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rrc_host_model_inst.write_reg(a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic oe;
    rrc_host_model_inst.read_reg(a, d, oe);
    check($sformatf("read %h", a), d, e);
    check("read drive enable", oe, 1'b1);
    check("drive released", rdata_oe, 1'b0);
  endtask : rd_chk

  // Bounded wait for the clock status to reach a level
  task automatic wait_ok(input logic exp, output int cnt);
    cnt = 0;
    while (clk_ok !== exp && cnt < 400) begin
      cyc(1);
      cnt++;
    end
    check("clk ok", clk_ok, exp);
  endtask : wait_ok

  task automatic test_done;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clock_in);
    num_errors++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    cyc(4);
    rd_chk(ADDR_GEN_CTRL_RD, RST_GEN_CTRL);
    rd_chk(ADDR_TX_MIX_RD, RST_TX_MIX);
    rd_chk(ADDR_LO_RD, RST_LO);
    rd_chk(ADDR_STATUS_RD, 8'h00);
    // Slow host for the plain read-back pass
    rrc_host_model_inst.half = 12;
    wr(ADDR_GEN_CTRL_WR, 8'h5a);
    wr(ADDR_TX_MIX_WR, 8'ha5);
    wr(ADDR_LO_WR, 8'h3c);
    wr(8'h35, 8'hff);
    rd_chk(ADDR_GEN_CTRL_RD, 8'h5a);
    rd_chk(ADDR_TX_MIX_RD, 8'ha5);
    rd_chk(ADDR_LO_RD, 8'h3c);
    rd_chk(8'h80, 8'h00);
    rrc_host_model_inst.half = 6;
    // Every divide and mode pairing, including the unsupported one
    for (logic [7:0] lo = 8'h00; lo < 8'h03; lo++) begin
      for (logic [7:0] t = 8'h00; t < 8'h04; t++) begin
        wr(ADDR_LO_WR, lo);
        wr(ADDR_TX_MIX_WR, t);
        check("image reject", ctrl.tx_image_reject, t[0] & (lo != 8'h00));
        check("high side", ctrl.tx_high_side, t[1]);
        check("lo divide", ctrl.lo_div, lo[1:0]);
        rd_chk(ADDR_TX_MIX_RD, t);
      end
    end
    foreach (gv[i]) begin
      wr(ADDR_GEN_CTRL_WR, gv[i]);
      check("refamp on", refamp_on, |gv[i][2:0]);
      check("synth enables", {ctrl.rf_synth_en, ctrl.if_synth_en}, {gv[i][0], gv[i][1]});
    end
    // Reference present but amplifier off: digital clock stays held
    mclk_run = 1'b1;
    cyc(200);
    check("clk ok while amp off", clk_ok, 1'b0);
    check("dig clk while amp off", dig_hi, 0);
    wr(ADDR_GEN_CTRL_WR, 8'h04);
    wait_ok(1'b1, n);
    check("clk ok too early", n >= 100, 1'b1);
    cyc(100);
    check("dig clk running", dig_hi > 0, 1'b1);
    rd_chk(ADDR_STATUS_RD, 8'h80);
    mclk_run = 1'b0;
    wait_ok(1'b0, n);
    check("loss too early", n >= 50, 1'b1);
    rd_chk(ADDR_STATUS_RD, 8'h00);
    mclk_run = 1'b1;
    wr(ADDR_GEN_CTRL_WR, 8'h01);
    wait_ok(1'b1, n);
    wr(ADDR_GEN_CTRL_WR, 8'h00);
    wait_ok(1'b0, n);
    mclk_run = 1'b0;
    cyc(20);
    // Loss of either rail
    for (int j = 0; j < 2; j++) begin
      {dig_ok, ana_ok} = (j == 0) ? 2'b01 : 2'b10;
      cyc(2);
      check("power down early", power_down, 1'b0);
      cyc(1);
      check("power down", power_down, 1'b1);
      rd_chk(ADDR_STATUS_RD, 8'h40);
      {dig_ok, ana_ok} = 2'b11;
      cyc(4);
      check("power restored", power_down, 1'b0);
    end
    // Command, pin and power-on reset must all land in one state
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_GEN_CTRL_WR, 8'h03);
      wr(ADDR_TX_MIX_WR, 8'h03);
      wr(ADDR_LO_WR, 8'h02);
      if (k == 0) begin
        rrc_host_model_inst.gen_reset();
      end else if (k == 1) begin
        ext_reset_low = 1'b0;
        cyc(6);
        ext_reset_low = 1'b1;
      end else begin
        arst_n_in = 1'b0;
        cyc(2);
        arst_n_in = 1'b1;
      end
      cyc(6);
      check("ctrl after reset", ctrl, 6'h00);
      check("refamp after reset", refamp_on, 1'b0);
      rd_chk(ADDR_GEN_CTRL_RD, RST_GEN_CTRL);
      rd_chk(ADDR_TX_MIX_RD, RST_TX_MIX);
      rd_chk(ADDR_LO_RD, RST_LO);
    end
    test_done();
  end
endmodule : rrc_top_tb
